// ---- rtl/rcms_sequencer.sv ----
// Purpose: system reset combiner, oscillator control and operation mode sequencer
// Assumes: mclk is the always-on 10 MHz clock; pads and analog flags are asynchronous
// Notes:   mode transitions are taken one cycle after their cause
`timescale 1ns/1ns
module rcms_sequencer
	import rcms_pkg::*;
(
	// clock and reset
	input  wire logic           mclk,
	input  wire logic           rst,
	// reset sources
	input  wire logic           master_clear_pin_n,
	input  wire logic           power_on_det,
	input  wire logic           brown_out_reset,
	input  wire logic           software_reset_req,
	input  wire logic           watchdog_reset,
	// wake and activity events
	input  wire logic           i2c_start_det,
	input  wire logic           hand_detect,
	input  wire logic           inactivity_timeout,
	input  wire logic           fast_oscillator_ready,
	// decoded host messages
	input  wire rcms_host_msg_t host_msg,
	// outputs
	output logic                system_reset_out,
	output rcms_ctrl_t          ctrl,
	output rcms_mode_t          mode_state,
	output logic                scan_pulse,
	output logic                slow_oscillator_tick
);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] sync3;
	logic             i2c_rise;
	logic             hand_rise;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1 <= {NSYNC{1'b0}};
			sync2 <= {NSYNC{1'b0}};
			sync3 <= {NSYNC{1'b0}};
		end else begin
			sync1 <= {hand_detect, i2c_start_det, brown_out_reset, power_on_det,
				~master_clear_pin_n};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign i2c_rise  = sync2[SY_I2C] & ~sync3[SY_I2C];
	assign hand_rise = sync2[SY_HAND] & ~sync3[SY_HAND];

	logic fosc_s1;
	logic fosc_rdy;

	always_ff @(posedge mclk) begin
		if (rst) begin
			fosc_s1  <= 1'b0;
			fosc_rdy <= 1'b0;
		end else begin
			fosc_s1  <= fast_oscillator_ready;
			fosc_rdy <= fosc_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slow oscillator tick
	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;
	logic             next_slow_tick;

	always_comb begin
		next_slow_tick = 1'b0;
		next_div_cnt   = div_cnt + 1'b1;
		if (div_cnt == DIV_W'(SLOW_DIV - 1)) begin
			next_div_cnt   = '0;
			next_slow_tick = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			div_cnt              <= '0;
			slow_oscillator_tick <= 1'b0;
		end else begin
			div_cnt              <= next_div_cnt;
			slow_oscillator_tick <= next_slow_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset combiner
	logic [PWRUP_W-1:0] pwrup_cnt;
	logic [PWRUP_W-1:0] next_pwrup_cnt;
	logic               pwrup_done;
	logic               wdt_fire;
	logic               rst_src;

	assign pwrup_done = (pwrup_cnt == PWRUP_W'(PWRUP_CYC));
	assign wdt_fire   = watchdog_reset & ctrl.watchdog_en;
	// brown-out keeps reset asserted past the power-up delay
	assign rst_src    = sync2[SY_MASTER_CLEAR_PIN] | software_reset_req | wdt_fire
		| ~pwrup_done | sync2[SY_BOR];

	always_comb begin
		next_pwrup_cnt = pwrup_cnt;
		if (sync2[SY_POR])
			next_pwrup_cnt = '0;
		else if (!pwrup_done)
			next_pwrup_cnt = pwrup_cnt + 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pwrup_cnt        <= '0;
			system_reset_out <= 1'b1;
		end else begin
			pwrup_cnt        <= next_pwrup_cnt;
			system_reset_out <= rst_src;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode sequencer and wake timer
	rcms_mode_t        next_mode;
	logic [WAKE_W-1:0] wake_period;
	logic [WAKE_W-1:0] next_wake_period;
	logic [WAKE_W-1:0] wake_cnt;
	logic [WAKE_W-1:0] next_wake_cnt;
	logic [1:0]        scan_cnt;
	logic [1:0]        next_scan_cnt;
	logic              next_scan_pulse;
	logic              scan_active;
	rcms_ctrl_t        next_ctrl;

	assign scan_active = (scan_cnt != 2'h0);

	function automatic rcms_ctrl_t ctrl_of(input rcms_mode_t m, input logic scan);
		rcms_ctrl_t c;
		c.fast_oscillator_en         = (m != ST_SLEEP) && (m != ST_WOA || scan);
		c.signal_processing_unit_run = (m == ST_PROC);
		c.watchdog_en                = (m == ST_PROC) || (m == ST_WOA);
		c.detect_en                  = (m == ST_PROC) || (m == ST_WOA && scan);
		c.tracking_en                = (m == ST_PROC);
		c.power_domains_en           = (m == ST_PROC);
		return c;
	endfunction : ctrl_of

	always_comb begin
		next_mode        = mode_state;
		next_wake_period = wake_period;
		next_wake_cnt    = wake_cnt;
		next_scan_cnt    = scan_cnt;
		next_scan_pulse  = 1'b0;
		if (host_msg.valid && host_msg.wake_period != '0)
			next_wake_period = host_msg.wake_period;
		if (rst_src) begin
			next_mode = ST_RESET;
		end else begin
			case (mode_state)
				ST_RESET: begin
					next_mode = ST_WAKE;
				end
				ST_WAKE: begin
					if (fosc_rdy)
						next_mode = ST_PROC;
				end
				ST_PROC: begin
					if (host_msg.valid && host_msg.target == MSG_WOA)
						next_mode = ST_WOA;
					else if (host_msg.valid && host_msg.target == MSG_SLEEP)
						next_mode = ST_SLEEP;
					else if (inactivity_timeout)
						next_mode = ST_WOA;
				end
				ST_WOA: begin
					if (i2c_rise || (hand_rise && scan_active))
						next_mode = ST_WAKE;
					else if (host_msg.valid && host_msg.target == MSG_SLEEP)
						next_mode = ST_SLEEP;
				end
				ST_SLEEP: begin
					// nothing inside the device leaves sleep without the host
					if (i2c_rise)
						next_mode = ST_WAKE;
				end
				default: begin
					next_mode = ST_RESET;
				end
			endcase
		end
		if (next_mode != ST_WOA || mode_state != ST_WOA) begin
			next_wake_cnt = next_wake_period;
			next_scan_cnt = 2'h0;
		end else if (slow_oscillator_tick) begin
			if (scan_active)
				next_scan_cnt = scan_cnt - 1'b1;
			if (wake_cnt <= 16'h0001) begin
				next_wake_cnt   = wake_period;
				next_scan_cnt   = SCAN_TICKS;
				next_scan_pulse = 1'b1;
			end else begin
				next_wake_cnt = wake_cnt - 1'b1;
			end
		end
		next_ctrl = ctrl_of(next_mode, next_scan_cnt != 2'h0);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_state  <= ST_RESET;
			wake_period <= WAKE_DEF;
			wake_cnt    <= WAKE_DEF;
			scan_cnt    <= 2'h0;
			scan_pulse  <= 1'b0;
			ctrl        <= '0;
		end else begin
			mode_state  <= next_mode;
			wake_period <= next_wake_period;
			wake_cnt    <= next_wake_cnt;
			scan_cnt    <= next_scan_cnt;
			scan_pulse  <= next_scan_pulse;
			ctrl        <= next_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	property p_master_clear_pin_reset;
		@(posedge mclk) disable iff (rst)
		sync2[SY_MASTER_CLEAR_PIN] |=> system_reset_out && mode_state == ST_RESET;
	endproperty
	a_master_clear_pin_reset: assert property (p_master_clear_pin_reset) else $error("master clear missed");

	property p_bor_hold;
		@(posedge mclk) disable iff (rst)
		pwrup_done && sync2[SY_BOR] |=> system_reset_out;
	endproperty
	a_bor_hold: assert property (p_bor_hold) else $error("brown-out not held");

	property p_sleep_fosc;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_SLEEP |-> !ctrl.fast_oscillator_en;
	endproperty
	a_sleep_fosc: assert property (p_sleep_fosc) else $error("fast osc on in sleep");

	property p_sleep_halt;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_SLEEP |-> !ctrl.signal_processing_unit_run
			&& !ctrl.watchdog_en && !ctrl.detect_en;
	endproperty
	a_sleep_halt: assert property (p_sleep_halt) else $error("activity in sleep");

	property p_proc_all_on;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_PROC |-> ctrl.power_domains_en
			&& ctrl.signal_processing_unit_run && ctrl.fast_oscillator_en;
	endproperty
	a_proc_all_on: assert property (p_proc_all_on) else $error("processing not full");

	property p_track_proc;
		@(posedge mclk) disable iff (rst)
		ctrl.tracking_en |-> mode_state == ST_PROC;
	endproperty
	a_track_proc: assert property (p_track_proc) else $error("tracking outside proc");

	property p_slow_period;
		@(posedge mclk) disable iff (rst)
		slow_oscillator_tick |-> ##[312:312] slow_oscillator_tick;
	endproperty
	a_slow_period: assert property (p_slow_period) else $error("slow tick period");

	property p_wake_fosc;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_WAKE && fosc_rdy && !rst_src |=> mode_state == ST_PROC;
	endproperty
	a_wake_fosc: assert property (p_wake_fosc) else $error("no proc after osc ready");

	property p_sleep_exit;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_SLEEP && i2c_rise && !rst_src |=> mode_state == ST_WAKE;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit missed");

	property p_proc_to_woa;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_PROC && host_msg.valid && host_msg.target == MSG_WOA
			&& !rst_src |=> mode_state == ST_WOA;
	endproperty
	a_proc_to_woa: assert property (p_proc_to_woa) else $error("woa entry missed");

	property p_hand_wake;
		@(posedge mclk) disable iff (rst)
		mode_state == ST_WOA && hand_rise && scan_active && !rst_src
			|=> mode_state == ST_WAKE && ctrl.fast_oscillator_en && !ctrl.tracking_en;
	endproperty
	a_hand_wake: assert property (p_hand_wake) else $error("hand wake missed");

	property p_scan_pulse;
		@(posedge mclk) disable iff (rst)
		scan_pulse |-> mode_state == ST_WOA && scan_active && ctrl.detect_en;
	endproperty
	a_scan_pulse: assert property (p_scan_pulse) else $error("scan outside woa");

endmodule : rcms_sequencer

// ---- rtl/rcms_pkg.sv ----
// Purpose: constants and types for the reset, clock and operation mode sequencer
// Assumes: one 10 MHz clock; the slow oscillator rate is an enable pulse
// Notes:   host messages arrive already decoded from the serial interface
// Operation
// - any of five sources asserts system reset
// - brown-out extends power-up reset until cleared
// - fast oscillator clocks transmit, converters, processing
// - fast oscillator stopped during deep sleep
// - slow oscillator tick clocks power-saving logic
// - processing entry and exit events
// - wake-on-approach entry and exit events
// - deep sleep via message, halts everything
// - processing keeps all domains and units active
// - tracking and gestures only in processing
// - power saving configured by host messages
// - serial start or master clear ends sleep
// - programmable slow-clock wake timer drives scans
package rcms_pkg;
	localparam int CLK_HZ      = 10_000_000;
	localparam int SLOW_HZ     = 32_000;
	localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;
	localparam int DIV_W       = $clog2(SLOW_DIV);
	localparam int PWRUP_NS    = 64_000;
	localparam int PWRUP_CYC   = (PWRUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PWRUP_W     = $clog2(PWRUP_CYC + 1);
	localparam int WAKE_W      = 16;
	localparam logic [WAKE_W-1:0] WAKE_DEF = 16'h0C80;
	localparam logic [1:0] SCAN_TICKS = 2'h2;
	localparam int NSYNC       = 5;
	localparam int SY_MASTER_CLEAR_PIN     = 0;
	localparam int SY_POR      = 1;
	localparam int SY_BOR      = 2;
	localparam int SY_I2C      = 3;
	localparam int SY_HAND     = 4;

	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_PROC  = 3'b001,
		ST_WOA   = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE  = 3'b100
	} rcms_mode_t;

	typedef enum logic [1:0] {
		MSG_PROC  = 2'b00,
		MSG_WOA   = 2'b01,
		MSG_SLEEP = 2'b10,
		MSG_NONE  = 2'b11
	} rcms_target_t;

	typedef struct packed {
		logic               valid;
		rcms_target_t       target;
		logic [WAKE_W-1:0]  wake_period;
	} rcms_host_msg_t;

	typedef struct packed {
		logic fast_oscillator_en;
		logic signal_processing_unit_run;
		logic watchdog_en;
		logic detect_en;
		logic tracking_en;
		logic power_domains_en;
	} rcms_ctrl_t;
endpackage : rcms_pkg

// ---- sim/rcms_host_model.sv ----
// Purpose: application host model: decoded messages, start flag, master clear pad
// Assumes: drives its lines 5 ns after mclk rises
// Notes:   a message field shows the inverse once valid drops
`timescale 1ns/1ns
module rcms_host_model
	import rcms_pkg::*;
(
	// clock
	input  wire logic      mclk,
	// towards the device
	output rcms_host_msg_t host_msg,
	output logic           i2c_start_det,
	output logic           master_clear_pin_n
);
	initial begin
		host_msg           = '{1'b0, MSG_NONE, 16'h0000};
		i2c_start_det      = 1'b0;
		master_clear_pin_n = 1'b1;
	end

	// power saving is set only through messages
	task automatic send_msg(input rcms_target_t t, input logic [WAKE_W-1:0] p);
		@(posedge mclk) #5;
		host_msg = '{1'b1, t, p};
		@(posedge mclk) #5;
		host_msg = '{1'b0, MSG_NONE, ~p};
	endtask : send_msg

	// the host alone ends deep sleep: start flag or master clear, n cycles
	task automatic pulse(input int n, input logic mc);
		@(posedge mclk) #5;
		if (mc) begin
			master_clear_pin_n = 1'b0;
		end else begin
			i2c_start_det = 1'b1;
		end
		repeat (n) @(posedge mclk);
		#5;
		master_clear_pin_n = 1'b1;
		i2c_start_det      = 1'b0;
	endtask : pulse
endmodule : rcms_host_model

// ---- sim/rcms_sequencer_tb.sv ----
// Purpose: self-checking bench for the reset, clock and mode sequencer
// Assumes: 10 MHz mclk, inputs driven 5 ns after the rising edge
// Notes:   fast oscillator ready follows its enable one cycle later
`timescale 1ns/1ns
module rcms_sequencer_tb;
	import rcms_pkg::*;

	logic           mclk, rst, power_on_det, brown_out_reset, software_reset_req;
	logic           watchdog_reset, hand_detect, inactivity_timeout, fast_oscillator_ready;
	logic           system_reset_out, scan_pulse, slow_oscillator_tick;
	logic           i2c_start_det, master_clear_pin_n;
	rcms_host_msg_t host_msg;
	rcms_ctrl_t     ctrl;
	rcms_mode_t     mode_state;
	int             mismatches, samples_checked, cycles, n;
	logic [15:0]    per;
	time            t0;

	rcms_host_model host (.mclk(mclk), .host_msg(host_msg), .i2c_start_det(i2c_start_det),
		.master_clear_pin_n(master_clear_pin_n));

	rcms_sequencer dut (.mclk(mclk), .rst(rst), .master_clear_pin_n(master_clear_pin_n),
		.power_on_det(power_on_det), .brown_out_reset(brown_out_reset),
		.software_reset_req(software_reset_req), .watchdog_reset(watchdog_reset),
		.i2c_start_det(i2c_start_det), .hand_detect(hand_detect),
		.inactivity_timeout(inactivity_timeout), .fast_oscillator_ready(fast_oscillator_ready),
		.host_msg(host_msg), .system_reset_out(system_reset_out), .ctrl(ctrl),
		.mode_state(mode_state), .scan_pulse(scan_pulse),
		.slow_oscillator_tick(slow_oscillator_tick));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) fast_oscillator_ready <= #5 ctrl.fast_oscillator_en;

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [5:0] exp_ctrl(input rcms_mode_t m);
		return (m == ST_PROC) ? 6'h3F : 6'h00;
	endfunction : exp_ctrl

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic wait_mode(input rcms_mode_t m, input int lim);
		int k;
		k = 0;
		while (mode_state !== m && k < lim) begin
			@(posedge mclk) #5;
			k++;
		end
		check("mode_state", 16'(mode_state), 16'(m));
	endtask : wait_mode

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, power_on_det, brown_out_reset, software_reset_req} = 4'h8;
		{watchdog_reset, hand_detect, inactivity_timeout} = 3'h0;
		{mismatches, samples_checked, cycles} = '0;
		per = 16'($urandom(32'h43E4));
		repeat (2) @(posedge mclk);
		#5 rst = 1'b0;
		repeat (600) @(posedge mclk);
		#5 check("sys_rst", system_reset_out, 16'h0001);
		wait_mode(ST_PROC, 200);
		check("ctrl", ctrl, exp_ctrl(ST_PROC));
		@(posedge slow_oscillator_tick);
		t0 = $time;
		@(posedge slow_oscillator_tick);
		check("tick_period", 16'(($time - t0) / 100), 16'(SLOW_DIV));
		$display("test power_up done");
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk) #5;
			software_reset_req = (i == 0);
			watchdog_reset = (i == 1);
			@(posedge mclk) #5;
			{software_reset_req, watchdog_reset} = 2'h0;
			check("sys_rst", system_reset_out, 16'h0001);
			wait_mode(ST_PROC, 50);
		end
		@(posedge mclk) #5;
		{power_on_det, brown_out_reset} = 2'h3;
		@(posedge mclk) #5;
		power_on_det = 1'b0;
		repeat (700) @(posedge mclk);
		#5 check("sys_rst", system_reset_out, 16'h0001);
		brown_out_reset = 1'b0;
		wait_mode(ST_PROC, 50);
		$display("test reset_sources done");
		per = 16'($urandom_range(4, 1));
		host.send_msg(MSG_WOA, per);
		wait_mode(ST_WOA, 5);
		check("fosc_en", ctrl.fast_oscillator_en, 16'h0000);
		check("tracking", ctrl.tracking_en, 16'h0000);
		n = 0;
		while (scan_pulse !== 1'b1 && n < (per + 1) * SLOW_DIV + 5) begin
			@(posedge mclk) #5;
			n++;
		end
		check("scan_pulse", scan_pulse, 16'h0001);
		hand_detect = 1'b1;
		wait_mode(ST_PROC, 20);
		hand_detect = 1'b0;
		@(posedge mclk) #5;
		inactivity_timeout = 1'b1;
		@(posedge mclk) #5;
		inactivity_timeout = 1'b0;
		wait_mode(ST_WOA, 3);
		host.pulse(3, 1'b0);
		wait_mode(ST_PROC, 20);
		$display("test wake_on_approach done");
		host.send_msg(MSG_SLEEP, 16'h0000);
		wait_mode(ST_SLEEP, 3);
		check("ctrl", ctrl, exp_ctrl(ST_SLEEP));
		// watchdog, approach and inactivity must all be ignored while asleep
		{watchdog_reset, hand_detect, inactivity_timeout} = 3'h7;
		host.send_msg(MSG_WOA, 16'h0001);
		{watchdog_reset, hand_detect, inactivity_timeout} = 3'h0;
		check("sys_rst", system_reset_out, 16'h0000);
		check("mode_state", 16'(mode_state), 16'(ST_SLEEP));
		host.pulse(3, 1'b0);
		wait_mode(ST_PROC, 20);
		host.send_msg(MSG_SLEEP, 16'h0000);
		wait_mode(ST_SLEEP, 3);
		host.pulse(4, 1'b1);
		check("sys_rst", system_reset_out, 16'h0001);
		wait_mode(ST_PROC, 50);
		$display("test deep_sleep done");
		stop_test();
	end
endmodule : rcms_sequencer_tb
